// ---- core/cti_params.svh ----
// Purpose: constants shared by both ends of the trigger and interrupt control link
// Assumes: 250 MHz module clock
// Notes: offsets in the configuration window are byte offsets on 16-bit words
//
// Overview of operation
// - status low byte: ones, address during acknowledge
// - mask bit 1 blocks its source
// - global enable low: 1 disables all interrupts
// - level codes 0..6 pick IRQ7..IRQ1, 7 disconnects
// - control bits 2..0 read as ones
// - host waits 3 ms after user storage write
// - registers take 16-bit only, bulk memory also 32
// - operational block decoded at offset register base
// - sync: trigger clears or starts clock counters
// - sync used only with backplane-synchronous triggers
// - enable starts clock; in sync, after trigger
// - source 00 internal, 01 trigger line, 10 external
// - rate codes 200 kHz to 100 Hz, 2-5-10
// - trigger-line clock used only when clock-in enabled
// - backplane trigger drives panel output and source 1
// - line select fields are binary line numbers
// - panel trigger routed if enabled, always source 2
// - clock-out drives sample clock onto chosen line
// - limit status driven onto chosen line when enabled
// - chosen line trigger starts post-trigger countdown
// - software keeps stop bit zero with transient enable
// - status read or acknowledge clears source flags
// - setup bit 0: run when 1, setup when 0
`ifndef CTI_PARAMS_SVH
`define CTI_PARAMS_SVH

// timing
`define CTI_CLK_HZ 250000000
`define CTI_BASE_HZ 200000
`define CTI_NV_WAIT_MS 3

// configuration window offsets
`define CTI_OFFSET_OFS 6'h06
`define CTI_ISR_OFS 6'h1a
`define CTI_ICR_OFS 6'h1c
`define CTI_SUBCLASS_OFS 6'h1e
`define CTI_SUFFIX_HI_OFS 6'h20
`define CTI_SUFFIX_LO_OFS 6'h22
`define CTI_USER_OFS 6'h24
`define CTI_USER_BASE_IDX 5'h12

// operational window offsets
`define CTI_CLKSEL_OFS 24'h000000
`define CTI_TRIG1_OFS 24'h000002
`define CTI_TRIG2_OFS 24'h000004
`define CTI_SETUP_OFS 24'h000006
`define CTI_BULK_OFS 24'h400000

// reset and fixed values
`define CTI_ICR_RST 16'hffff
`define CTI_ICR_ONES 16'h0047
`define CTI_SUBCLASS_VAL 16'hfffe
`define CTI_LEVEL_OFF 3'h7

// host command register fields
`define CTI_HOST_ADDR_IDX 3'h0
`define CTI_HOST_CTRL_IDX 3'h1
`define CTI_HOST_WDATA_IDX 3'h2
`define CTI_HOST_RDATA_IDX 3'h3
`define CTI_HOST_STAT_IDX 3'h4

`endif

// ---- core/cti_pkg.sv ----
// Purpose: types used by the module and controller ends
// Assumes: nothing
// Notes: constants live in cti_params.svh
package cti_pkg;
  typedef logic [15:0] cti_word_t;
  typedef logic [31:0] cti_addr_t;
  typedef enum {CTI_H_IDLE, CTI_H_HOLD, CTI_H_ISSUE} cti_host_state_t;
endpackage : cti_pkg

// ---- core/cti_link_if.sv ----
// Purpose: backplane register link between host and module
// Assumes: one clock shared by both ends
// Notes: req holds until ack, ack is a one-cycle pulse
`timescale 1ns/10ps
interface cti_link_if;
  logic req;
  logic [31:0] addr;
  logic a32;
  logic wr;
  logic d32;
  logic iack;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic ack;
  logic berr;
  logic [7:1] irq;
  modport dev (input req, addr, a32, wr, d32, iack, wdata,
               output rdata, ack, berr, irq);
  modport host (output req, addr, a32, wr, d32, iack, wdata,
                input rdata, ack, berr, irq);
endinterface : cti_link_if

// ---- core/cti_device.sv ----
// Purpose: module side: interrupt, sample clock and trigger routing registers
// Assumes: trigger and panel inputs synchronous to i_sys_clk
// Notes: trigger lines are asserted high, oe follows the driven bits
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "cti_params.svh"
module cti_device #(
  parameter logic BIG_MEM = 1'b0,
  parameter logic LOW_RATE = 1'b0,
  // arbitrary option codes
  parameter logic [15:0] SUFFIX_HI = 16'h5a5a,
  parameter logic [15:0] SUFFIX_LO = 16'h5a5a
) (
  // clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // backplane link
  cti_link_if.dev link,
  // identity
  input wire logic [7:0] i_logical_addr,
  // backplane trigger lines
  input wire logic [7:0] i_ttl_trig,
  output logic [7:0] o_ttl_trig_o,
  output logic [7:0] o_ttl_trig_oe,
  // front panel
  input wire logic i_fp_trig,
  input wire logic i_ext_clk,
  output logic o_fp_trig,
  // acquisition side
  input wire logic i_limit_violation,
  input wire logic i_transient_done,
  input wire logic [3:0] i_segment_full,
  output logic o_sample_clk,
  output logic o_post_trigger_start,
  output cti_pkg::cti_word_t o_setup
);
  import cti_pkg::*;

  cti_word_t clk_sel;
  cti_word_t trig1;
  cti_word_t trig2;
  cti_word_t int_ctrl;
  cti_word_t offset_reg;
  cti_word_t user_mem [14];
  cti_word_t rd_word;
  logic [7:0] flags;
  logic [7:0] events;
  logic [7:0] ttl_prev;
  logic [7:0] ttl_edge;
  logic [7:0] next_drive;
  logic fp_prev;
  logic ext_prev;
  logic lv_prev;
  logic ttl_in_evt;
  logic cfg_hit;
  logic a32_hit;
  logic take;
  logic sel;
  logic d32_bad;
  logic wr_ok;
  logic irq_on;
  logic flag_clr;
  logic [5:0] cofs;
  logic [23:0] aofs;
  logic [3:0] user_idx;
  logic [10:0] pre_cnt;
  logic [10:0] mul_cnt;
  logic [10:0] div;
  logic started;
  logic run;
  logic int_tick;
  logic src_pulse;
  logic sync_evt;

  // period of each rate in steps of the 200 kHz base
  function automatic logic [10:0] rate_mult(input logic [3:0] code);
    case (code)
      4'h1: rate_mult = LOW_RATE ? 11'h000 : 11'h001;
      4'h2: rate_mult = 11'h002;
      4'h3: rate_mult = 11'h004;
      4'h4: rate_mult = 11'h00a;
      4'h5: rate_mult = 11'h014;
      4'h6: rate_mult = 11'h028;
      4'h7: rate_mult = 11'h064;
      4'h8: rate_mult = 11'h0c8;
      4'h9: rate_mult = 11'h190;
      4'ha: rate_mult = 11'h3e8;
      4'hb: rate_mult = 11'h7d0;
      default: rate_mult = 11'h000;
    endcase
  endfunction : rate_mult

  localparam logic [10:0] BASE_LAST = 11'(`CTI_CLK_HZ / `CTI_BASE_HZ - 1);

  // decode
  assign cofs = link.addr[5:0];
  assign aofs = link.addr[23:0];
  assign user_idx = 4'(cofs[5:1] - `CTI_USER_BASE_IDX);
  assign cfg_hit = ~link.a32 & (link.addr[15:14] == 2'h3) &
                   (link.addr[13:6] == i_logical_addr);
  assign a32_hit = link.a32 & (BIG_MEM ? (link.addr[31:25] == offset_reg[15:9]) :
                   (link.addr[31:24] == offset_reg[15:8]));
  assign take = i_ce & link.req & ~link.ack;
  assign sel = take & (link.iack ? (irq_on &
               (link.addr[2:0] == 3'(`CTI_LEVEL_OFF - int_ctrl[5:3])))
               : (cfg_hit | a32_hit));
  assign d32_bad = link.d32 & ~link.iack & ~(a32_hit & (aofs >= `CTI_BULK_OFS));
  assign wr_ok = sel & link.wr & ~link.iack & ~d32_bad;

  // interrupt request
  assign irq_on = (|(flags & ~int_ctrl[15:8])) & ~int_ctrl[7] &
                  (int_ctrl[5:3] != `CTI_LEVEL_OFF);
  always_comb begin
    link.irq = 7'h00;
    if (irq_on) begin
      link.irq[3'(`CTI_LEVEL_OFF - int_ctrl[5:3])] = 1'b1;
    end
  end

  // read mux
  always_comb begin
    rd_word = 16'hffff;
    if (link.iack) begin
      rd_word = {flags, i_logical_addr};
    end else if (cfg_hit) begin
      if (cofs == `CTI_ISR_OFS) begin
        rd_word = {flags, 8'hff};
      end else if (cofs == `CTI_ICR_OFS) begin
        rd_word = int_ctrl | `CTI_ICR_ONES;
      end else if (cofs == `CTI_OFFSET_OFS) begin
        rd_word = offset_reg;
      end else if (cofs == `CTI_SUBCLASS_OFS) begin
        rd_word = `CTI_SUBCLASS_VAL;
      end else if (cofs == `CTI_SUFFIX_HI_OFS) begin
        rd_word = SUFFIX_HI;
      end else if (cofs == `CTI_SUFFIX_LO_OFS) begin
        rd_word = SUFFIX_LO;
      end else if (cofs >= `CTI_USER_OFS) begin
        rd_word = user_mem[user_idx];
      end
    end else if (aofs == `CTI_CLKSEL_OFS) begin
      rd_word = {8'hff, clk_sel[7:0]};
    end else if (aofs == `CTI_TRIG1_OFS) begin
      rd_word = trig1;
    end else if (aofs == `CTI_TRIG2_OFS) begin
      rd_word = trig2;
    end else if (aofs == `CTI_SETUP_OFS) begin
      rd_word = o_setup;
    end
  end

  // link answer, one cycle after the request is seen
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      link.ack <= 1'b0;
      link.berr <= 1'b0;
      link.rdata <= 32'h0;
    end else if (i_ce) begin
      link.ack <= sel;
      link.berr <= sel & d32_bad;
      if (sel) begin
        link.rdata <= {16'h0, rd_word};
      end
    end
  end

  // configuration writes
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      int_ctrl <= `CTI_ICR_RST;
      offset_reg <= 16'h0;
    end else if (wr_ok & cfg_hit) begin
      if (cofs == `CTI_ICR_OFS) begin
        int_ctrl <= link.wdata[15:0];
      end else if (cofs == `CTI_OFFSET_OFS) begin
        offset_reg <= {link.wdata[15:8], 8'h00};
      end
    end
  end

  // user storage, timing kept by the host
  always_ff @(posedge i_sys_clk) begin
    if (wr_ok & cfg_hit & (cofs >= `CTI_USER_OFS)) begin
      user_mem[user_idx] <= link.wdata[15:0];
    end
  end

  // operational writes
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      clk_sel <= 16'h0;
      trig1 <= 16'h0;
      trig2 <= 16'h0;
      o_setup <= 16'h0;
    end else if (wr_ok & a32_hit) begin
      if (aofs == `CTI_CLKSEL_OFS) begin
        clk_sel <= link.wdata[15:0];
      end else if (aofs == `CTI_TRIG1_OFS) begin
        trig1 <= link.wdata[15:0];
      end else if (aofs == `CTI_TRIG2_OFS) begin
        trig2 <= link.wdata[15:0];
      end else if (aofs == `CTI_SETUP_OFS) begin
        o_setup <= link.wdata[15:0];
      end
    end
  end

  // input edges
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ttl_prev <= 8'h0;
      fp_prev <= 1'b0;
      ext_prev <= 1'b0;
      lv_prev <= 1'b0;
    end else if (i_ce) begin
      ttl_prev <= i_ttl_trig;
      fp_prev <= i_fp_trig;
      ext_prev <= i_ext_clk;
      lv_prev <= i_limit_violation;
    end
  end
  assign ttl_edge = i_ttl_trig & ~ttl_prev;
  assign ttl_in_evt = trig1[15] & ttl_edge[trig1[14:12]];
  assign sync_evt = ttl_edge[trig1[14:12]];

  // source flags, a new event wins over the clear
  assign events = {i_transient_done, i_segment_full, i_fp_trig & ~fp_prev,
                   ttl_in_evt, i_limit_violation & ~lv_prev};
  assign flag_clr = sel & ~link.wr & (link.iack | (cfg_hit & (cofs == `CTI_ISR_OFS)));
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      flags <= 8'h0;
    end else if (i_ce) begin
      flags <= (flag_clr ? 8'h0 : flags) | events;
    end
  end

  // internal sample clock generator
  assign div = rate_mult(clk_sel[3:0]);
  assign run = clk_sel[6] & (~clk_sel[7] | started);
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_cnt <= 11'h0;
      mul_cnt <= 11'h0;
      started <= 1'b0;
      int_tick <= 1'b0;
    end else if (i_ce) begin
      int_tick <= 1'b0;
      if (~clk_sel[6]) begin
        started <= 1'b0;
      end else if (clk_sel[7] & sync_evt) begin
        started <= 1'b1;
      end
      if (clk_sel[7] & sync_evt) begin
        pre_cnt <= 11'h0;
        mul_cnt <= 11'h0;
      end else if (run & (div != 11'h0)) begin
        if (pre_cnt == BASE_LAST) begin
          pre_cnt <= 11'h0;
          if (mul_cnt >= 11'(div - 11'h1)) begin
            mul_cnt <= 11'h0;
            int_tick <= 1'b1;
          end else begin
            mul_cnt <= 11'(mul_cnt + 11'h1);
          end
        end else begin
          pre_cnt <= 11'(pre_cnt + 11'h1);
        end
      end
    end
  end

  // clock source select
  always_comb begin
    case (clk_sel[5:4])
      2'h0: src_pulse = int_tick;
      2'h1: src_pulse = trig1[7] & ttl_edge[trig1[6:4]];
      2'h2: src_pulse = i_ext_clk & ~ext_prev;
      default: src_pulse = 1'b0;
    endcase
  end

  // trigger line drive
  always_comb begin
    next_drive = 8'h0;
    if (trig1[11] & i_fp_trig & ~fp_prev) begin
      next_drive[trig1[10:8]] = 1'b1;
    end
    if (trig1[3] & src_pulse) begin
      next_drive[trig1[2:0]] = 1'b1;
    end
    if (trig2[11] & i_limit_violation) begin
      next_drive[trig2[10:8]] = 1'b1;
    end
  end

  // registered outputs
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ttl_trig_o <= 8'h0;
      o_ttl_trig_oe <= 8'h0;
      o_fp_trig <= 1'b0;
      o_sample_clk <= 1'b0;
      o_post_trigger_start <= 1'b0;
    end else if (i_ce) begin
      o_ttl_trig_o <= next_drive;
      o_ttl_trig_oe <= next_drive;
      o_fp_trig <= ttl_in_evt;
      o_sample_clk <= run & src_pulse;
      o_post_trigger_start <= (trig2[3] & ttl_edge[trig2[2:0]]) |
        (wr_ok & a32_hit & (aofs == `CTI_SETUP_OFS) & link.wdata[2]);
    end
  end
endmodule : cti_device

// ---- core/cti_host.sv ----
// Purpose: controller side: AHB-Lite command registers driving the link
// Assumes: one master, zero-wait slave
// Notes: user storage writes start a settle timer that holds later user storage accesses
`timescale 1ns/10ps
`include "cti_params.svh"
module cti_host #(
  parameter int NV_WAIT_CYCLES = `CTI_CLK_HZ / 1000 * `CTI_NV_WAIT_MS
) (
  // clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire cti_pkg::cti_addr_t i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // backplane link
  cti_link_if.host link
);
  import cti_pkg::*;

  cti_host_state_t state;
  cti_addr_t cmd_addr;
  logic [31:0] cmd_wdata;
  logic [31:0] rdata;
  logic [3:0] cmd;
  logic [2:0] ph_idx;
  logic ph_wr;
  logic go;
  logic berr;
  logic refused;
  logic cur_user;
  logic nv_load;
  logic [31:0] nv_cnt;
  logic [31:0] rd_mux;

  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign cur_user = ~cmd[1] & ~cmd[3] & (cmd_addr[5:0] >= `CTI_USER_OFS);
  assign go = ph_wr & (ph_idx == `CTI_HOST_CTRL_IDX) & i_hwdata[0];

  // address phase capture
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ph_wr <= 1'b0;
      ph_idx <= 3'h0;
    end else if (i_ce & i_hready) begin
      ph_wr <= i_hsel & i_htrans[1] & i_hwrite;
      ph_idx <= i_haddr[4:2];
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    if (i_haddr[4:2] == `CTI_HOST_ADDR_IDX) begin
      rd_mux = cmd_addr;
    end else if (i_haddr[4:2] == `CTI_HOST_CTRL_IDX) begin
      rd_mux = {27'h0, cmd, 1'b0};
    end else if (i_haddr[4:2] == `CTI_HOST_WDATA_IDX) begin
      rd_mux = cmd_wdata;
    end else if (i_haddr[4:2] == `CTI_HOST_RDATA_IDX) begin
      rd_mux = rdata;
    end else if (i_haddr[4:2] == `CTI_HOST_STAT_IDX) begin
      rd_mux = {16'h0, link.irq, 5'h0, nv_cnt != 32'h0, refused, berr,
                state != CTI_H_IDLE};
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hrdata <= 32'h0;
    end else if (i_ce & i_hready & i_hsel & i_htrans[1] & ~i_hwrite) begin
      o_hrdata <= rd_mux;
    end
  end

  // command registers, frozen while busy
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_addr <= 32'h0;
      cmd_wdata <= 32'h0;
      cmd <= 4'h0;
    end else if (i_ce & ph_wr & (state == CTI_H_IDLE)) begin
      if (ph_idx == `CTI_HOST_ADDR_IDX) begin
        cmd_addr <= i_hwdata;
      end else if (ph_idx == `CTI_HOST_CTRL_IDX) begin
        cmd <= i_hwdata[4:1];
      end else if (ph_idx == `CTI_HOST_WDATA_IDX) begin
        cmd_wdata <= i_hwdata;
      end
    end
  end

  // settle timer after user storage writes
  assign nv_load = (state == CTI_H_ISSUE) & link.ack & cmd[0] & cur_user;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      nv_cnt <= 32'h0;
    end else if (i_ce) begin
      if (nv_load) begin
        nv_cnt <= 32'(NV_WAIT_CYCLES);
      end else if (nv_cnt != 32'h0) begin
        nv_cnt <= nv_cnt - 32'h1;
      end
    end
  end

  // link sequencer
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= CTI_H_IDLE;
      link.req <= 1'b0;
      link.addr <= 32'h0;
      link.a32 <= 1'b0;
      link.wr <= 1'b0;
      link.d32 <= 1'b0;
      link.iack <= 1'b0;
      link.wdata <= 32'h0;
      rdata <= 32'h0;
      berr <= 1'b0;
      refused <= 1'b0;
    end else if (i_ce) begin
      case (state)
        CTI_H_IDLE: begin
          if (go) begin
            link.addr <= cmd_addr;
            link.a32 <= i_hwdata[2];
            link.wr <= i_hwdata[1] & ~i_hwdata[4];
            link.d32 <= i_hwdata[3];
            link.iack <= i_hwdata[4];
            link.wdata <= cmd_wdata;
            if (i_hwdata[2] & i_hwdata[1] & (cmd_addr[23:0] == `CTI_TRIG2_OFS) &
                cmd_wdata[3]) begin
              link.wdata[7] <= 1'b0;
            end
            refused <= i_hwdata[3] & ~i_hwdata[2];
            if (~(i_hwdata[3] & ~i_hwdata[2])) begin
              state <= CTI_H_HOLD;
            end
          end
        end
        CTI_H_HOLD: begin
          if (~cur_user | (nv_cnt == 32'h0)) begin
            link.req <= 1'b1;
            state <= CTI_H_ISSUE;
          end
        end
        CTI_H_ISSUE: begin
          if (link.ack) begin
            link.req <= 1'b0;
            rdata <= link.rdata;
            berr <= link.berr;
            state <= CTI_H_IDLE;
          end
        end
        default: state <= CTI_H_IDLE;
      endcase
    end
  end
endmodule : cti_host

// ---- test/cti_link_monitor.sv ----
// Purpose: protocol checks on the link between controller and module
// Assumes: LADDR and A32_BASE match the bench setup
// Notes: watches only the shared link signals
`timescale 1ns/10ps
module cti_link_monitor #(
  parameter logic [7:0] LADDR = 8'h00,
  parameter logic [7:0] A32_BASE = 8'h20
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // link signals
  input wire logic req,
  input wire logic [31:0] addr,
  input wire logic a32,
  input wire logic wr,
  input wire logic d32,
  input wire logic iack,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic ack,
  input wire logic berr,
  input wire logic [7:1] irq
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic cfg_rd;
  assign cfg_rd = ack && !wr && !a32 && !iack;
  hold_req_a: assert property (req && !ack |=> req && $stable(addr) && $stable(wdata))
    else $error("request changed before its answer");
  req_drop_a: assert property (ack |=> !req)
    else $error("request held after answer");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("answer longer than one cycle");
  decode_hit_a: assert property ($rose(req) && !iack && ((a32 && addr[31:24] == A32_BASE) ||
      (!a32 && addr[15:6] == {2'b11, LADDR})) |=> ack)
    else $error("decoded access not answered next cycle");
  berr_ack_a: assert property (berr |-> ack)
    else $error("bus error without answer");
  d32_reg_a: assert property (ack && d32 && (!a32 || addr[23:0] < 24'h400000) |-> berr)
    else $error("wide transfer to register accepted");
  d16_ok_a: assert property (ack && !d32 |-> !berr)
    else $error("narrow transfer refused");
  isr_ones_a: assert property (cfg_rd && addr[5:0] == 6'h1a |-> rdata[7:0] == 8'hff)
    else $error("status low byte not all ones");
  iack_addr_a: assert property (ack && iack |-> rdata[7:0] == LADDR)
    else $error("acknowledge did not return logical address");
  icr_ones_a: assert property (cfg_rd && addr[5:0] == 6'h1c |-> rdata[2:0] == 3'h7)
    else $error("unused control bits not ones");
  one_level_a: assert property ($onehot0(irq))
    else $error("more than one request line driven");
endmodule : cti_link_monitor

// ---- test/testbench.sv ----
// Purpose: self-checking bench for controller and module joined by the link
// Assumes: settle timer shortened to NVW cycles
// Notes: software side reaches the controller over AHB-Lite
`timescale 1ns/10ps
module testbench;
  import cti_pkg::*;
  localparam logic [7:0] LADDR = 8'h2c;
  localparam int NVW = 20;
  localparam logic [4:0] R = 5'h01;
  localparam logic [4:0] W = 5'h03;
  localparam logic [4:0] AR = 5'h05;
  localparam logic [4:0] AW = 5'h07;
  localparam logic [4:0] IA = 5'h11;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [7:0] ttl_in = 8'h0;
  logic [7:0] ttl_o;
  logic [7:0] ttl_oe;
  logic fp_in = 1'b0;
  logic ext_clk = 1'b0;
  logic fp_out;
  logic lim = 1'b0;
  logic tdone = 1'b0;
  logic [3:0] segf = 4'h0;
  logic sclk;
  logic pts;
  cti_word_t setup;
  logic [7:0] tseen;
  logic [7:0] oseen;
  logic fseen;
  logic pseen;
  logic sseen;
  logic [31:0] r;
  int n;
  int n_fail = 0;
  int total_checks = 0;

  always #2 i_sys_clk = ~i_sys_clk;

  cti_link_if u_cti_link_if();
  cti_device u_cti_device (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(1'b1),
    .link(u_cti_link_if), .i_logical_addr(LADDR), .i_ttl_trig(ttl_in),
    .o_ttl_trig_o(ttl_o), .o_ttl_trig_oe(ttl_oe), .i_fp_trig(fp_in), .i_ext_clk(ext_clk),
    .o_fp_trig(fp_out), .i_limit_violation(lim), .i_transient_done(tdone),
    .i_segment_full(segf), .o_sample_clk(sclk), .o_post_trigger_start(pts), .o_setup(setup));
  cti_host #(.NV_WAIT_CYCLES(NVW)) u_cti_host (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_ce(1'b1), .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout), .o_hreadyout(hreadyout),
    .o_hresp(hresp), .o_hrdata(hrdata), .link(u_cti_link_if));
  cti_link_monitor #(.LADDR(LADDR), .A32_BASE(8'h20)) u_cti_link_monitor (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .req(u_cti_link_if.req), .addr(u_cti_link_if.addr),
    .a32(u_cti_link_if.a32), .wr(u_cti_link_if.wr), .d32(u_cti_link_if.d32),
    .iack(u_cti_link_if.iack), .wdata(u_cti_link_if.wdata), .rdata(u_cti_link_if.rdata),
    .ack(u_cti_link_if.ack), .berr(u_cti_link_if.berr), .irq(u_cti_link_if.irq));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge i_sys_clk);
    while (!hreadyout) @(posedge i_sys_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge i_sys_clk);
    while (!hreadyout) @(posedge i_sys_clk);
    q = hrdata;
  endtask : ahb

  task automatic st;
    ahb(1'b0, 32'h10, 32'h0, r);
  endtask : st

  // one link transfer: address, data, go, wait for idle, fetch result
  task automatic acc(input logic [4:0] ctl, input logic [23:0] off, input logic [15:0] d,
                     output logic [31:0] q);
    logic [31:0] a;
    logic [31:0] s;
    int k;
    a = ctl[2] ? {8'h20, off} : ctl[4] ? {8'h0, off} : {16'h0, 2'b11, LADDR, off[5:0]};
    ahb(1'b1, 32'h0, a, s);
    ahb(1'b1, 32'h8, {16'h0, d}, s);
    ahb(1'b1, 32'h4, {27'h0, ctl}, s);
    k = 0;
    do begin
      ahb(1'b0, 32'h10, 32'h0, s);
      k++;
    end while (s[0] && k < 500);
    check(32'(s[0]), 32'h0);
    ahb(1'b0, 32'hc, 32'h0, q);
  endtask : acc

  task automatic watch(input int cyc);
    {tseen, oseen, fseen, pseen, sseen} = '0;
    repeat (cyc) begin
      @(negedge i_sys_clk);
      tseen |= ttl_o;
      oseen |= ttl_oe;
      fseen |= fp_out;
      pseen |= pts;
      sseen |= sclk;
    end
    @(posedge i_sys_clk);
  endtask : watch

  task automatic kick(input logic [7:0] t, input logic f, input logic e, input int cyc);
    ttl_in <= t;
    fp_in <= f;
    ext_clk <= e;
    @(posedge i_sys_clk);
    ttl_in <= 8'h0;
    fp_in <= 1'b0;
    ext_clk <= 1'b0;
    watch(cyc);
  endtask : kick

  task automatic gap(output int c);
    c = 0;
    do begin
      @(negedge i_sys_clk);
      c++;
    end while (!sclk && c < 6000);
    @(posedge i_sys_clk);
  endtask : gap

  task automatic t_reset;
    acc(R, 24'h1c, 16'h0, r);
    check(32'(r[15:0]), 32'hffff);
    acc(W, 24'h06, 16'h2000, r);
    acc(W, 24'h04, 16'h8000, r);
    acc(R, 24'h1e, 16'h0, r);
    check(32'(r[15:0]), 32'hfffe);
    $display("test reset done");
  endtask : t_reset

  task automatic t_irq;
    acc(W, 24'h1c, 16'hfb00, r);
    kick(8'h0, 1'b1, 1'b0, 4);
    check(32'(tseen), 32'h0);
    for (int c = 0; c < 8; c++) begin
      acc(W, 24'h1c, 16'hfb00 | 16'(c << 3), r);
      acc(R, 24'h1c, 16'h0, r);
      check(32'(r[15:0]), 32'hfb47 | 32'(c << 3));
      st;
      check(32'(r[15:9]), c == 7 ? 32'h0 : 32'h1 << (6 - c));
    end
    acc(W, 24'h1c, 16'hff10, r);
    st;
    check(32'(r[15:9]), 32'h0);
    acc(W, 24'h1c, 16'hfb90, r);
    st;
    check(32'(r[15:9]), 32'h0);
    acc(W, 24'h1c, 16'hfb10, r);
    st;
    check(32'(r[15:9]), 32'h10);
    acc(IA, 24'h5, 16'h0, r);
    check(32'(r[7:0]), 32'(LADDR));
    st;
    check(32'(r[15:9]), 32'h0);
    kick(8'h0, 1'b1, 1'b0, 4);
    acc(R, 24'h1a, 16'h0, r);
    check(32'(r[15:0]), 32'h04ff);
    st;
    check(32'(r[15:9]), 32'h0);
    tdone <= 1'b1;
    segf <= 4'h1;
    @(posedge i_sys_clk);
    {tdone, segf} <= 5'h0;
    acc(R, 24'h1a, 16'h0, r);
    check(32'(r[15:8]), 32'h88);
    $display("test irq done");
  endtask : t_irq

  task automatic t_route;
    for (int k = 0; k < 8; k++) begin
      acc(AW, 24'h2, 16'h8800 | 16'(k << 12) | 16'((7 - k) << 8), r);
      kick(8'h1 << k, 1'b0, 1'b0, 4);
      check(32'(fseen), 32'h1);
      kick(8'h0, 1'b1, 1'b0, 4);
      check(32'(tseen), 32'h1 << (7 - k));
      check(32'(oseen), 32'h1 << (7 - k));
    end
    acc(AR, 24'h2, 16'h0, r);
    check(32'(r[15:0]), 32'hf800);
    acc(AW, 24'h2, 16'h0, r);
    kick(8'h01, 1'b1, 1'b0, 4);
    check(32'(fseen), 32'h0);
    check(32'(tseen), 32'h0);
    $display("test route done");
  endtask : t_route

  task automatic t_lines;
    acc(AW, 24'h4, 16'h0b0d, r);
    lim <= 1'b1;
    watch(4);
    lim <= 1'b0;
    check(32'(tseen), 32'h08);
    kick(8'h20, 1'b0, 1'b0, 4);
    check(32'(pseen), 32'h1);
    acc(AW, 24'h4, 16'h0005, r);
    kick(8'h20, 1'b0, 1'b0, 4);
    check(32'(pseen), 32'h0);
    acc(AW, 24'h6, 16'h0001, r);
    check(32'(setup[0]), 32'h1);
    acc(AW, 24'h6, 16'h0000, r);
    check(32'(setup[0]), 32'h0);
    $display("test lines done");
  endtask : t_lines

  task automatic t_bus;
    acc(5'h0f, 24'h2, 16'h1234, r);
    st;
    check(32'(r[1]), 32'h1);
    check(32'(hresp), 32'h0);
    acc(5'h0b, 24'h1c, 16'h0, r);
    st;
    check(32'(r[2]), 32'h1);
    acc(AR, 24'h2, 16'h0, r);
    check(32'(r[15:0]), 32'h0);
    acc(W, 24'h24, 16'h3c3c, r);
    st;
    check(32'(r[3]), 32'h1);
    acc(R, 24'h24, 16'h0, r);
    check(32'(r[15:0]), 32'h3c3c);
    $display("test bus done");
  endtask : t_bus

  task automatic t_clk;
    for (int k = 1; k < 4; k++) begin
      acc(AW, 24'h0, 16'h0040 | 16'(k), r);
      gap(n);
      gap(n);
      check(32'(n), 32'(1250 << (k - 1)));
    end
    acc(AW, 24'h2, 16'h6000, r);
    acc(AW, 24'h0, 16'h0000, r);
    acc(AW, 24'h0, 16'h00c1, r);
    watch(1400);
    check(32'(sseen), 32'h0);
    kick(8'h40, 1'b0, 1'b0, 0);
    gap(n);
    check(32'(n), 32'h4e3);
    acc(AW, 24'h0, 16'h0050, r);
    acc(AW, 24'h2, 16'h00a0, r);
    kick(8'h04, 1'b0, 1'b0, 6);
    check(32'(sseen), 32'h1);
    acc(AW, 24'h2, 16'h0020, r);
    kick(8'h04, 1'b0, 1'b0, 6);
    check(32'(sseen), 32'h0);
    acc(AW, 24'h0, 16'h0060, r);
    acc(AW, 24'h2, 16'h000c, r);
    kick(8'h0, 1'b0, 1'b1, 6);
    check(32'(sseen), 32'h1);
    check(32'(tseen), 32'h10);
    acc(AW, 24'h0, 16'h0000, r);
    $display("test clock done");
  endtask : t_clk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    t_reset();
    t_irq();
    t_route();
    t_lines();
    t_bus();
    t_clk();
    end_sim();
  end

  // guards against a hung link transfer
  initial begin
    repeat (60000) @(posedge i_sys_clk);
    n_fail++;
    end_sim();
  end
endmodule : testbench
